// *** inc/gpio_cond_pkg.sv ***
// Constants for the general input/output condition unit.
// Assumes one system clock and a synchronous active-high reset.
package gpio_cond_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int NUM_LINES   = 8;
  localparam int ADC_BITS    = 12;
  localparam int NUM_CHAN    = 5;
  localparam int SYNC_STAGES = 2;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [3:0] OFS_INPUT_PORT  = 4'h0; // Synchronised inputs, read
  localparam logic [3:0] OFS_OUT_PATTERN = 4'h1; // Write: tri-state pattern
  localparam logic [3:0] OFS_OUT_STATE   = 4'h2; // Read: output state
  localparam logic [3:0] OFS_COMMAND     = 4'h3; // Write: start a command
  localparam logic [3:0] OFS_STATUS      = 4'h4; // Read: busy, done, error
  localparam logic [3:0] OFS_RESULT      = 4'h5; // Read: last input query or analogue value
  localparam logic [3:0] OFS_WAIT_PAT    = 4'h6; // Write: wait pattern
  localparam logic [3:0] OFS_THRESHOLD   = 4'h7; // Write: analogue threshold

  // ********************************************************************
  // Pattern digit codes, two bits per line
  // ********************************************************************
  localparam logic [1:0] DIGIT_LOW  = 2'h0;
  localparam logic [1:0] DIGIT_HIGH = 2'h1;
  localparam logic [1:0] DIGIT_SKIP = 2'h2;

  // ********************************************************************
  // Command codes, command register bits [2:0]; channel in bits [6:4]
  // ********************************************************************
  localparam logic [2:0] CMD_INPUT_QUERY = 3'h1;
  localparam logic [2:0] CMD_HOLD_MATCH  = 3'h2;
  localparam logic [2:0] CMD_ANALOG_READ = 3'h3;
  localparam logic [2:0] CMD_HOLD_ABOVE  = 3'h4;
  localparam logic [2:0] CMD_HOLD_BELOW  = 3'h5;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0]  RESET_OUTPUTS  = 8'h00;
  localparam logic [15:0] RESET_WAIT_PAT = 16'h0000;

  // ********************************************************************
  // Controller states
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MATCH = 2'b01,
    ST_ABOVE = 2'b11,
    ST_BELOW = 2'b10
  } cmd_state_e;

endpackage : gpio_cond_pkg

// *** logic/motion_io_port_conditions.sv ***
// General input/output unit: digital inputs, outputs, analogue conditions.
// Assumes converter samples arrive on this clock; digital inputs are async.

`timescale 1ns/1ps
`default_nettype none

module motion_io_port_conditions #(
  parameter int NUM_LINES = gpio_cond_pkg::NUM_LINES,
  parameter int ADC_BITS  = gpio_cond_pkg::ADC_BITS
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [3:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  input  wire logic [NUM_LINES-1:0]   input_pins,
  output logic      [NUM_LINES-1:0]   output_pins,
  input  wire logic [5*ADC_BITS-1:0]  adc_samples,
  output logic                        cmd_busy,
  output logic                        cmd_done,
  output logic                        cmd_error
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Channel number 1..5 is valid
  function automatic logic chan_ok(input logic [2:0] ch);
    chan_ok = (ch >= 3'h1) && (ch <= 3'h5);
  endfunction : chan_ok

  // Signed 32-bit value of a channel; 1 and 2 signed, others unsigned
  function automatic logic signed [31:0] chan_value(
    input logic [5*ADC_BITS-1:0] s,
    input logic [2:0]            ch
  );
    logic [ADC_BITS-1:0] raw;
    raw = '0;
    chan_value = '0;
    if (chan_ok(ch)) begin
      raw = s[(32'(ch) - 32'd1) * ADC_BITS +: ADC_BITS];
      if (ch <= 3'h2) begin
        chan_value = 32'(signed'(raw));
      end else begin
        chan_value = 32'(raw);
      end
    end
  endfunction : chan_value

  // Strobe high at one register index
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [3:0] a,
    input logic [3:0] ofs
  );
    reg_hit = strobe && (a == ofs);
  endfunction : reg_hit

  // Output digit: off, on, or keep the present level
  function automatic logic digit_apply(
    input logic [1:0] d,
    input logic       cur
  );
    case (d)
      gpio_cond_pkg::DIGIT_LOW:  digit_apply = 1'b0;
      gpio_cond_pkg::DIGIT_HIGH: digit_apply = 1'b1;
      default:                   digit_apply = cur;
    endcase
  endfunction : digit_apply

  // Wait digit met by the line level; skip always met
  function automatic logic digit_ok(
    input logic [1:0] d,
    input logic       level
  );
    case (d)
      gpio_cond_pkg::DIGIT_LOW:  digit_ok = !level;
      gpio_cond_pkg::DIGIT_HIGH: digit_ok = level;
      default:                   digit_ok = 1'b1;
    endcase
  endfunction : digit_ok

  // ********************************************************************
  // Input synchroniser
  // ********************************************************************
  logic [NUM_LINES-1:0] sync1_reg;
  logic [NUM_LINES-1:0] sync2_reg;
  logic [NUM_LINES-1:0] inputs_now;

  // Two stages; only stage two is read by logic
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= input_pins;
      sync2_reg <= sync1_reg;
    end
  end
  assign inputs_now = sync2_reg;

  // ********************************************************************
  // Digital outputs
  // ********************************************************************
  logic [NUM_LINES-1:0] out_reg;
  logic [NUM_LINES-1:0] out_next;

  // Apply tri-state pattern, two bits per line, line 8 in top bits
  always_comb begin
    out_next = out_reg;
    if (reg_hit(wr, addr, gpio_cond_pkg::OFS_OUT_PATTERN)) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        out_next[i] = digit_apply(wdata[2*i +: 2], out_reg[i]);
      end
    end
  end

  // Outputs off from reset
  always_ff @(posedge clock) begin
    if (rst) begin
      out_reg <= NUM_LINES'(gpio_cond_pkg::RESET_OUTPUTS);
    end else begin
      out_reg <= out_next;
    end
  end
  assign output_pins = out_reg;

  // ********************************************************************
  // Command controller
  // ********************************************************************
  gpio_cond_pkg::cmd_state_e state_reg;
  gpio_cond_pkg::cmd_state_e state_next;

  // Setup values held for the pending wait
  logic [2*NUM_LINES-1:0]    wait_pat_reg;
  logic [2*NUM_LINES-1:0]    wait_pat_next;
  logic signed [31:0]        thresh_reg;
  logic signed [31:0]        thresh_next;
  logic [2:0]                chan_reg;
  logic [2:0]                chan_next;

  // Results and acknowledge
  logic [31:0]               result_reg;
  logic [31:0]               result_next;
  logic                      done_reg;
  logic                      done_next;
  logic                      error_reg;
  logic                      error_next;

  // Combinational views of inputs and strobes
  logic                      pat_match;
  logic signed [31:0]        cur_val;
  logic [2:0]                cmd_code;
  logic [2:0]                cmd_chan;
  logic                      idle;
  logic                      pat_wr;
  logic                      thr_wr;
  logic                      cmd_wr;

  // Command fields and the value under watch
  assign cmd_code = wdata[2:0];
  assign cmd_chan = wdata[6:4];
  assign cur_val  = chan_value(adc_samples, chan_reg);

  // Setup and command writes count only while idle
  assign idle   = (state_reg == gpio_cond_pkg::ST_IDLE);
  assign pat_wr = reg_hit(wr, addr, gpio_cond_pkg::OFS_WAIT_PAT) && idle;
  assign thr_wr = reg_hit(wr, addr, gpio_cond_pkg::OFS_THRESHOLD) && idle;
  assign cmd_wr = reg_hit(wr, addr, gpio_cond_pkg::OFS_COMMAND) && idle;

  // Pattern compare; digit 2 ignores the line. Unwritten leading
  // digits hold code zero, so they require low.
  always_comb begin
    pat_match = 1'b1;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!digit_ok(wait_pat_reg[2*i +: 2], inputs_now[i])) begin
        pat_match = 1'b0;
      end
    end
  end

  // Next state, setup registers and results
  // A pending wait has no time limit; only its condition or reset ends it
  always_comb begin
    state_next    = state_reg;
    wait_pat_next = wait_pat_reg;
    thresh_next   = thresh_reg;
    chan_next     = chan_reg;
    result_next   = result_reg;
    done_next     = 1'b0;
    error_next    = error_reg;
    if (pat_wr) begin
      wait_pat_next = wdata[2*NUM_LINES-1:0];
    end
    if (thr_wr) begin
      thresh_next = signed'(wdata);
    end
    case (state_reg)
      gpio_cond_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          error_next = 1'b0;
          chan_next  = cmd_chan;
          case (cmd_code)
            gpio_cond_pkg::CMD_INPUT_QUERY: begin
              result_next = 32'(inputs_now);
              done_next   = 1'b1;
            end
            gpio_cond_pkg::CMD_HOLD_MATCH: begin
              state_next = gpio_cond_pkg::ST_MATCH;
            end
            gpio_cond_pkg::CMD_ANALOG_READ: begin
              if (chan_ok(cmd_chan)) begin
                result_next = chan_value(adc_samples, cmd_chan);
              end else begin
                error_next = 1'b1;
              end
              done_next = 1'b1;
            end
            gpio_cond_pkg::CMD_HOLD_ABOVE, gpio_cond_pkg::CMD_HOLD_BELOW: begin
              if (!chan_ok(cmd_chan)) begin
                error_next = 1'b1;
                done_next  = 1'b1;
              end else if (cmd_code == gpio_cond_pkg::CMD_HOLD_ABOVE) begin
                state_next = gpio_cond_pkg::ST_ABOVE;
              end else begin
                state_next = gpio_cond_pkg::ST_BELOW;
              end
            end
            default: begin
              error_next = 1'b1;
              done_next  = 1'b1;
            end
          endcase
        end
      end
      gpio_cond_pkg::ST_MATCH: begin
        if (pat_match) begin
          state_next = gpio_cond_pkg::ST_IDLE;
          done_next  = 1'b1;
        end
      end
      gpio_cond_pkg::ST_ABOVE: begin
        if (cur_val > thresh_reg) begin
          result_next = cur_val;
          state_next  = gpio_cond_pkg::ST_IDLE;
          done_next   = 1'b1;
        end
      end
      gpio_cond_pkg::ST_BELOW: begin
        if (cur_val < thresh_reg) begin
          result_next = cur_val;
          state_next  = gpio_cond_pkg::ST_IDLE;
          done_next   = 1'b1;
        end
      end
      default: begin
        state_next = gpio_cond_pkg::ST_IDLE;
      end
    endcase
  end

  // Controller registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg    <= gpio_cond_pkg::ST_IDLE;
      wait_pat_reg <= (2*NUM_LINES)'(gpio_cond_pkg::RESET_WAIT_PAT);
      thresh_reg   <= '0;
      chan_reg     <= '0;
      result_reg   <= '0;
      done_reg     <= 1'b0;
      error_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      wait_pat_reg <= wait_pat_next;
      thresh_reg   <= thresh_next;
      chan_reg     <= chan_next;
      result_reg   <= result_next;
      done_reg     <= done_next;
      error_reg    <= error_next;
    end
  end

  // ********************************************************************
  // Status outputs
  // ********************************************************************

  // Busy from the state, done and error from flip-flops
  assign cmd_busy  = (state_reg != gpio_cond_pkg::ST_IDLE);
  assign cmd_done  = done_reg;
  assign cmd_error = error_reg;

  // ********************************************************************
  // Register read port
  // ********************************************************************
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Read data one cycle after the strobe, zero otherwise
  // Out-pattern, command and unmapped indices read as zero; wait pattern and threshold read back
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd) begin
      case (addr)
        gpio_cond_pkg::OFS_INPUT_PORT:  rdata_next = 32'(inputs_now);
        gpio_cond_pkg::OFS_OUT_STATE:   rdata_next = 32'(out_reg);
        gpio_cond_pkg::OFS_STATUS:      rdata_next = {29'h0, error_reg, done_reg, cmd_busy};
        gpio_cond_pkg::OFS_RESULT:      rdata_next = result_reg;
        gpio_cond_pkg::OFS_WAIT_PAT:    rdata_next = 32'(wait_pat_reg);
        gpio_cond_pkg::OFS_THRESHOLD:   rdata_next = thresh_reg;
        default:                        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata = rdata_reg;

endmodule : motion_io_port_conditions

`default_nettype wire

// *** verification/motion_io_port_monitor.sv ***
// Checker for the input/output condition unit, bound to its top module.
// Assumes the register map and command codes of gpio_cond_pkg.
`timescale 1ns/1ps
`default_nettype none
module motion_io_port_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  output_pins,
  input wire logic        cmd_busy,
  input wire logic        cmd_done,
  input wire logic        cmd_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Command write that the idle unit takes
  logic cmd_go;
  logic out_wr;
  assign cmd_go = wr && addr == gpio_cond_pkg::OFS_COMMAND && !cmd_busy;
  assign out_wr = wr && addr == gpio_cond_pkg::OFS_OUT_PATTERN;
  chk_reset_off: assert property (disable iff (1'b0) rst |=> output_pins == 8'h00)
    else $error("outputs not off after reset");
  chk_out_on: assert property (out_wr && wdata[1:0] == 2'h1 |=> output_pins[0])
    else $error("output one not switched on");
  chk_out_off: assert property (out_wr && wdata[1:0] == 2'h0 |=> !output_pins[0])
    else $error("output one not switched off");
  chk_out_hold: assert property (out_wr && wdata[3:2] == 2'h2 |=> $stable(output_pins[1]))
    else $error("output two changed on skip digit");
  chk_state_read: assert property (rd && addr == gpio_cond_pkg::OFS_OUT_STATE
    |=> rdata == {24'h000000, $past(output_pins)})
    else $error("output state readback wrong");
  chk_query_width: assert property (rd && addr == gpio_cond_pkg::OFS_INPUT_PORT
    |=> rdata[31:8] == 24'h000000)
    else $error("input port wider than eight lines");
  chk_wait_busy: assert property (cmd_go && wdata[2:0] == gpio_cond_pkg::CMD_HOLD_MATCH
    |=> cmd_busy)
    else $error("pattern wait not pending");
  chk_done_pulse: assert property (cmd_done && !cmd_go |=> !cmd_done)
    else $error("done longer than one cycle");
  chk_bad_chan: assert property (cmd_go && wdata[2:0] == gpio_cond_pkg::CMD_ANALOG_READ
    && (wdata[6:4] == 3'h0 || wdata[6:4] > 3'h5) |=> cmd_done && cmd_error)
    else $error("bad channel not refused");
  chk_quick_done: assert property (cmd_go && wdata[2:0] == gpio_cond_pkg::CMD_INPUT_QUERY
    |=> cmd_done && !cmd_error)
    else $error("input query not acknowledged");
  chk_wait_ends: assert property (cmd_done && $past(cmd_busy) |-> !cmd_busy)
    else $error("busy stays with done");
  cover property (cmd_done && cmd_error);
  cover property (cmd_busy ##1 cmd_done);
  cover property (rd && addr == gpio_cond_pkg::OFS_RESULT);
endmodule : motion_io_port_monitor
bind motion_io_port_conditions motion_io_port_monitor motion_io_port_monitor_i (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .output_pins(output_pins), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_error(cmd_error));
`default_nettype wire

// *** verification/io_far_side.sv ***
// Switches and analogue sources on the far side of the unit.
// Assumes unwired lines are pulled low; levels are converter codes.
`timescale 1ns/1ps
`default_nettype none
module io_far_side (
  input  wire logic        clock,
  input  wire logic [7:0]  sw_closed,
  input  wire logic [7:0]  sw_wired,
  input  wire logic [59:0] levels,
  output logic      [7:0]  input_pins,
  output logic      [59:0] adc_samples
);
  // Contacts and codes change just after the edge
  always_ff @(posedge clock) begin
    input_pins  <= sw_closed & sw_wired;
    adc_samples <= levels;
  end
endmodule : io_far_side
`default_nettype wire

// *** verification/tb_motion_io_port_conditions.sv ***
// Self-checking bench for the input/output condition unit.
// Assumes the register map of gpio_cond_pkg and the far-side model.
`timescale 1ns/1ps
`default_nettype none
module tb_motion_io_port_conditions;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  sw_closed = 8'h00;
  logic [7:0]  sw_wired = 8'hFF;
  logic [7:0]  input_pins;
  logic [7:0]  output_pins;
  logic [59:0] levels = {12'h7F8, 12'h000, 12'hFFF, 12'h7FF, 12'h801};
  logic [59:0] adc_samples;
  logic        cmd_busy;
  logic        cmd_done;
  logic        cmd_error;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #12.5 clock = ~clock;
  motion_io_port_conditions motion_io_port_conditions_i (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .input_pins(input_pins),
    .output_pins(output_pins), .adc_samples(adc_samples), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .cmd_error(cmd_error));
  io_far_side io_far_side_i (.clock(clock), .sw_closed(sw_closed), .sw_wired(sw_wired),
    .levels(levels), .input_pins(input_pins), .adc_samples(adc_samples));
  // ******************************************************************
  // Bus tasks and comparison
  // ******************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk
  // Bounded wait for the acknowledge pulse
  task automatic wait_done(input logic err);
    int n;
    n = 0;
    #1;
    while (cmd_done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    check({31'h0, cmd_done}, 32'h1);
    check({31'h0, cmd_error}, {31'h0, err});
  endtask : wait_done
  function automatic logic [31:0] cmd(input logic [2:0] code, input logic [2:0] ch);
    return {25'h0, ch, 1'b0, code};
  endfunction : cmd
  function automatic logic [31:0] exp_adc(input int ch);
    logic [11:0] s;
    s = levels[(ch-1)*12 +: 12];
    return (ch < 3) ? {{20{s[11]}}, s} : {20'h0, s};
  endfunction : exp_adc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd_chk(gpio_cond_pkg::OFS_OUT_STATE, 32'h0);
    sw_closed <= 8'hA5;
    sw_wired <= 8'h3F;
    repeat (5) @(posedge clock);
    rd_chk(gpio_cond_pkg::OFS_INPUT_PORT, 32'h25);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_INPUT_QUERY, 3'h0));
    wait_done(1'b0);
    rd_chk(gpio_cond_pkg::OFS_RESULT, 32'h25);
    wr_reg(gpio_cond_pkg::OFS_OUT_PATTERN, 32'h5555);
    rd_chk(gpio_cond_pkg::OFS_OUT_STATE, 32'hFF);
    wr_reg(gpio_cond_pkg::OFS_OUT_PATTERN, 32'h9388);
    rd_chk(gpio_cond_pkg::OFS_OUT_STATE, 32'hDA);
    check({24'h0, output_pins}, 32'hDA);
    $display("test io done");
    sw_wired <= 8'hFF;
    sw_closed <= 8'h82;
    wr_reg(gpio_cond_pkg::OFS_WAIT_PAT, 32'h0004);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_HOLD_MATCH, 3'h0));
    repeat (8) @(posedge clock);
    rd_chk(gpio_cond_pkg::OFS_STATUS, 32'h1);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_INPUT_QUERY, 3'h0));
    sw_closed <= 8'h02;
    wait_done(1'b0);
    wr_reg(gpio_cond_pkg::OFS_WAIT_PAT, 32'hAAA4);
    sw_closed <= 8'hF2;
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_HOLD_MATCH, 3'h0));
    wait_done(1'b0);
    $display("test match done");
    for (int c = 0; c < 8; c++) begin
      wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_ANALOG_READ, 3'(c)));
      wait_done(c < 1 || c > 5);
      if (c >= 1 && c <= 5)
        rd_chk(gpio_cond_pkg::OFS_RESULT, exp_adc(c));
    end
    wr_reg(gpio_cond_pkg::OFS_THRESHOLD, 32'h7F8);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_HOLD_ABOVE, 3'h5));
    repeat (6) @(posedge clock);
    rd_chk(gpio_cond_pkg::OFS_STATUS, 32'h1);
    levels[59:48] <= 12'h7F9;
    wait_done(1'b0);
    rd_chk(gpio_cond_pkg::OFS_RESULT, 32'h7F9);
    wr_reg(gpio_cond_pkg::OFS_THRESHOLD, 32'hFFFFF830);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_HOLD_BELOW, 3'h1));
    wait_done(1'b0);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(gpio_cond_pkg::CMD_HOLD_ABOVE, 3'h6));
    wait_done(1'b1);
    rd_chk(gpio_cond_pkg::OFS_STATUS, 32'h4);
    rd_chk(gpio_cond_pkg::OFS_RESULT, 32'hFFFFF801);
    wr_reg(gpio_cond_pkg::OFS_COMMAND, cmd(3'h7, 3'h1));
    wait_done(1'b1);
    $display("test analogue done");
    report_and_stop;
  end
endmodule : tb_motion_io_port_conditions
`default_nettype wire
